// *** core/fault_alarm_pkg.sv ***
// Constants, register map and carrier types for the fault alarm aggregator
// What this block does
// - Each fault source sets its own flag
// - State register read-only, read clears all
// - After clearing read, flags set again freely
// - Unmasked flags ORed onto open-drain alarm pin
// - Mask register, set bit disables source
// - Reset: thermal enabled, others masked
// - Clamps: voltage in FI, current in FV
// - FI clamp alarm needs clamp enable bit
// - Enabled clamp alarm still obeys mask
// - FV clamps always active, enable ignored
// - FV out-of-range levels keep static limit
// - FV alarm on clamp level or limit
// - Fault only flags and drives alarm pin and irq
// - Overvoltage thresholds from dedicated level DACs
// - Reset restores all control bits' defaults
package fault_alarm_pkg;

  // Word byte offsets on the Wishbone bus
  localparam logic [3:0] STATE_OFFSET = 4'h0;
  localparam logic [3:0] MASK_OFFSET = 4'h4;
  localparam logic [3:0] CTRL_OFFSET = 4'h8;
  localparam logic [3:0] LIMIT_OFFSET = 4'hC;

  // Alarm bit positions, shared by state and mask
  localparam int OV_LOW0_BIT = 0;
  localparam int OV_LOW1_BIT = 1;
  localparam int OV_HIGH0_BIT = 2;
  localparam int OV_HIGH1_BIT = 3;
  localparam int CLAMP0_BIT = 4;
  localparam int CLAMP1_BIT = 5;
  localparam int THERMAL_BIT = 6;
  localparam int ALARM_WIDTH = 7;

  // Mask reset: thermal enabled, overvoltage and clamp masked
  localparam logic [6:0] MASK_RESET = 7'h3F;

  // Control register fields
  localparam int CLAMP_ENABLE0_BIT = 0;
  localparam int CLAMP_ENABLE1_BIT = 1;
  localparam int FORCE_VOLTAGE0_BIT = 2;
  localparam int FORCE_VOLTAGE1_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Number of channels
  localparam int CHANNELS = 2;

  // Analog comparator outputs for one channel
  typedef struct packed {
    logic ov_low;          // Pin below overvoltage_low_level
    logic ov_high;         // Pin above overvoltage_high_level
    logic v_at_clamp_high; // Pin voltage at clamp_high_level
    logic v_at_clamp_low;  // Pin voltage at clamp_low_level
    logic i_at_clamp_high; // Source current at clamp_high_level
    logic i_at_clamp_low;  // Sink current at clamp_low_level
    logic i_static_limit;  // Current at static limit
    logic levels_in_range; // Clamp levels inside functional range
  } channel_sense_t;

  // Per-channel control handed to the qualifier
  typedef struct packed {
    logic force_voltage_mode;
    logic clamp_enable_bit;
  } channel_ctrl_t;

endpackage

// *** core/clamp_qualifier.sv ***
// Clamp alarm qualification for one channel of the parametric unit
`timescale 1ns/1ns
module clamp_qualifier (
  // Mode and enable
  input wire fault_alarm_pkg::channel_ctrl_t ctrl_i,
  // Comparator inputs
  input wire fault_alarm_pkg::channel_sense_t sense_i,
  // Qualified events
  output logic clamp_event_o,
  output logic static_limit_active_o
);
  import fault_alarm_pkg::*;

  // Voltage clamp hit in force_current_mode, gated by enable
  wire fi_hit = ctrl_i.clamp_enable_bit &
                (sense_i.v_at_clamp_high | sense_i.v_at_clamp_low);
  // Current clamp hit in force_voltage_mode, enable ignored
  wire fv_hit = sense_i.i_at_clamp_high | sense_i.i_at_clamp_low |
                sense_i.i_static_limit;

  // In force_voltage_mode, static limit stays in effect when levels out of range
  assign static_limit_active_o = ctrl_i.force_voltage_mode &
                                 ~sense_i.levels_in_range;
  // Mode selects the relevant clamp kind
  assign clamp_event_o = ctrl_i.force_voltage_mode ? fv_hit : fi_hit;

endmodule // clamp_qualifier

// *** core/fault_alarm_aggregator.sv ***
// Fault alarm aggregator: sticky alarm state, mask, Wishbone slave, open-drain alarm
`timescale 1ns/1ns
module fault_alarm_aggregator (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog sense inputs
  input wire fault_alarm_pkg::channel_sense_t sense0_i,
  input wire fault_alarm_pkg::channel_sense_t sense1_i,
  input wire logic thermal_i,
  // Open-drain alarm pin and interrupt
  output logic alarm_pin_o,
  output logic alarm_pin_oe_o,
  output logic irq_o,
  // Static current limit indication to analog side
  output logic [1:0] static_limit_o
);
  import fault_alarm_pkg::*;

  // Registers
  logic [6:0] state_q;   // Sticky alarm flags
  logic [6:0] state_d;
  logic [6:0] mask_q;    // Alarm mask, set disables
  logic [3:0] ctrl_q;    // Clamp enables and modes
  logic [31:0] dat_q;    // Read data
  logic ack_q;           // Bus acknowledge
  logic [1:0] limit_q;   // Registered static limit flags

  // Per-channel carriers
  channel_sense_t sense [CHANNELS];
  channel_ctrl_t chan_ctrl [CHANNELS];
  logic [1:0] clamp_event;
  logic [1:0] limit_active;

  assign sense[0] = sense0_i;
  assign sense[1] = sense1_i;

  // One qualifier per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      assign chan_ctrl[g].force_voltage_mode = ctrl_q[FORCE_VOLTAGE0_BIT + g];
      assign chan_ctrl[g].clamp_enable_bit = ctrl_q[CLAMP_ENABLE0_BIT + g];
      clamp_qualifier u_qual (
        .ctrl_i(chan_ctrl[g]),
        .sense_i(sense[g]),
        .clamp_event_o(clamp_event[g]),
        .static_limit_active_o(limit_active[g])
      );
    end
  endgenerate

  // Raw events, one bit per source, independent of each other
  wire [6:0] raw_event = {thermal_i, clamp_event[1], clamp_event[0],
                          sense1_i.ov_high, sense0_i.ov_high,
                          sense1_i.ov_low, sense0_i.ov_low};
  // Masked sources neither flag nor alarm
  wire [6:0] live_event = raw_event & ~mask_q;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_req = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_req = bus_req & ~wb_we_i;
  wire hit_state = (wb_adr_i == STATE_OFFSET);
  wire hit_mask = (wb_adr_i == MASK_OFFSET);
  wire hit_ctrl = (wb_adr_i == CTRL_OFFSET);
  wire hit_limit = (wb_adr_i == LIMIT_OFFSET);
  // Read clears state; writes to state are ignored
  wire state_clear = rd_req & hit_state;

  // Read mux, unmapped reads return zero
  wire [31:0] rd_mux = hit_state ? {25'h0000000, state_q} :
                       hit_mask ? {25'h0000000, mask_q} :
                       hit_ctrl ? {28'h0000000, ctrl_q} :
                       hit_limit ? {30'h00000000, limit_q} : 32'h00000000;

  // Next state: clear on read, new events win over clear
  always_comb begin
    state_d = state_clear ? 7'h00 : state_q;
    state_d = state_d | live_event;
  end

  // Alarm state flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= 7'h00;
    end else begin
      state_q <= state_d;
    end
  end

  // Control and mask registers, defaults under reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= MASK_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (wr_req && hit_mask) begin
      mask_q <= wb_dat_i[6:0];
    end else if (wr_req && hit_ctrl) begin
      ctrl_q <= wb_dat_i[3:0];
    end
  end

  // Bus acknowledge and read data, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      dat_q <= rd_req ? rd_mux : dat_q;
    end
  end

  // Static limit flags registered for the analog side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_q <= 2'h0;
    end else begin
      limit_q <= limit_active;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign static_limit_o = limit_q;
  // OR of flags pulls the open-drain pin low and drives irq_o; no other action taken
  assign irq_o = |state_q;
  assign alarm_pin_o = 1'b0;
  assign alarm_pin_oe_o = |state_q;

endmodule // fault_alarm_aggregator

// *** tb/fault_alarm_aggregator_props.sv ***
// Port checks for the fault alarm aggregator
`timescale 1ns/1ns
module fault_alarm_props (
  // Clock, reset, bus
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Sense and alarm
  input fault_alarm_pkg::channel_sense_t sense0_i,
  input fault_alarm_pkg::channel_sense_t sense1_i,
  input logic thermal_i,
  input logic alarm_pin_o,
  input logic alarm_pin_oe_o,
  input logic irq_o,
  input logic [1:0] static_limit_o
);
  import fault_alarm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Any raw fault input, before mask and clamp qualification
  wire ev_w = thermal_i | (|sense0_i[7:1]) | (|sense1_i[7:1]);
  a_pin_low: assert property (alarm_pin_o == 1'b0) else $error("pin driven high");
  a_irq_oe: assert property (irq_o == alarm_pin_oe_o) else $error("irq and pin differ");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i)) else $error("stray ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:7] == 25'h0) else $error("upper data");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(ev_w) || $past(ev_w, 2) || $past(ev_w, 3))
    else $error("alarm without fault");
  // Clearing read drops the flags on the same edge that raises ack, so ack stands with the fall
  a_irq_clear: assert property ($fell(irq_o) |-> (wb_ack_o & !wb_we_i) || $past(wb_ack_o & !wb_we_i) ||
    $past(wb_ack_o & !wb_we_i, 2) || $past(rst_i) || $past(rst_i, 2))
    else $error("alarm dropped");
  a_limit_cause: assert property ((static_limit_o & $past({sense1_i[0], sense0_i[0]})) == 2'h0)
    else $error("limit in range");
  c_alarm: cover property ($rose(irq_o));
  c_read: cover property (irq_o ##1 wb_ack_o);
  c_limit: cover property (static_limit_o != 2'h0);
endmodule // fault_alarm_props

// *** tb/fault_alarm_aggregator_test.sv ***
// Testbench for the fault alarm aggregator
`timescale 1ns/1ns
module fault_alarm_aggregator_test;
  import fault_alarm_pkg::*;
  localparam logic [7:0] IDLE = 8'h01; // Levels in range, no fault
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, alarm_pin_o, alarm_pin_oe_o, irq_o, thermal_i = 1'b0;
  logic [1:0] static_limit_o;
  channel_sense_t sense0_i = IDLE, sense1_i = IDLE;
  int error_cnt = 0, n_compared = 0, cyc_cnt = 0;
  fault_alarm_aggregator u_dut (.*);
  // Clock
  always #25 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // One classic Wishbone cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    @(posedge clk_i iff wb_ack_o === 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk("register", e, q);
  endtask
  // One-cycle fault pulse, then settle
  task automatic ev(input logic [7:0] s0, input logic [7:0] s1, input logic th);
    @(posedge clk_i);
    {sense0_i, sense1_i, thermal_i} <= {s0, s1, th};
    @(posedge clk_i);
    {sense0_i, sense1_i, thermal_i} <= {IDLE, IDLE, 1'b0};
    repeat (3) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(MASK_OFFSET, 32'h3F);
    rd(CTRL_OFFSET, 32'h0);
    rd(4'h2, 32'h0);
    ev(IDLE, IDLE, 1'b1);
    chk("irq", 32'h1, {31'h0, alarm_pin_oe_o & irq_o});
    rd(STATE_OFFSET, 32'h40);
    rd(STATE_OFFSET, 32'h0);
    ev(IDLE, IDLE, 1'b1);
    rd(STATE_OFFSET, 32'h40);
    ev(8'h81, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h0);
    $display("test thermal and mask done");
    wr(MASK_OFFSET, 32'h0, 4'hF);
    wr(MASK_OFFSET, 32'h3F, 4'h0);
    ev(8'h81, 8'h41, 1'b0);
    rd(STATE_OFFSET, 32'h09);
    wr(STATE_OFFSET, 32'h7F, 4'hF);
    rd(STATE_OFFSET, 32'h0);
    ev(8'h21, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h1, 4'hF);
    ev(8'h21, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h10);
    wr(MASK_OFFSET, 32'h10, 4'hF);
    ev(8'h21, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h0);
    $display("test force current done");
    wr(MASK_OFFSET, 32'h0, 4'hF);
    wr(CTRL_OFFSET, 32'hC, 4'hF);
    ev(IDLE, 8'h05, 1'b0);
    rd(STATE_OFFSET, 32'h20);
    ev(8'h03, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h10);
    ev(8'h21, IDLE, 1'b0);
    rd(STATE_OFFSET, 32'h0);
    sense0_i <= 8'h00;
    rd(LIMIT_OFFSET, 32'h1);
    chk("limit", 32'h1, {30'h0, static_limit_o});
    sense0_i <= IDLE;
    $display("test force voltage done");
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(MASK_OFFSET, 32'h3F);
    $display("test reset done");
    complete_run();
  end
endmodule // fault_alarm_aggregator_test
bind fault_alarm_aggregator fault_alarm_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .sense0_i, .sense1_i, .thermal_i, .alarm_pin_o,
  .alarm_pin_oe_o, .irq_o, .static_limit_o);
